// ---- verilog/spimsp_pkg.sv ----
// constants and shared types of the spi master/slave port
package spimsp_pkg;
	// ********************************************************
	// register indices; byte address is four times the index
	// ********************************************************
	localparam logic [7:0] CTRL_IDX = 8'h2C;
	localparam logic [7:0] STAT_IDX = 8'h2D;
	localparam logic [7:0] DATA_IDX = 8'h2E;
	localparam int ADDR_LSB = 2;
	localparam int ADDR_MSB = 9;
	// ********************************************************
	// field positions and reset values
	// ********************************************************
	localparam int CTRL_IE_BIT = 7;
	localparam int CTRL_EN_BIT = 6;
	localparam int CTRL_LSB_BIT = 5;
	localparam int CTRL_MASTER_SELECT_BIT = 4;
	localparam int CTRL_CLOCK_IDLE_POLARITY_BIT = 3;
	localparam int CTRL_CLOCK_SAMPLE_PHASE_BIT = 2;
	localparam int CTRL_R1_BIT = 1;
	localparam int CTRL_R0_BIT = 0;
	localparam int STAT_FLAG_BIT = 7;
	localparam int STAT_WRITE_COLLISION_FLAG_BIT = 6;
	localparam int STAT_DBL_BIT = 0;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] STAT_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	// ********************************************************
	// cycle counts
	// ********************************************************
	localparam logic [4:0] LAST_EDGE = 5'h0F;
	localparam logic [3:0] LAST_SAMPLE = 4'h7;
	localparam logic [6:0] HALF_D2 = 7'h01;
	localparam logic [6:0] HALF_D4 = 7'h02;
	localparam logic [6:0] HALF_D8 = 7'h04;
	localparam logic [6:0] HALF_D16 = 7'h08;
	localparam logic [6:0] HALF_D32 = 7'h10;
	localparam logic [6:0] HALF_D64 = 7'h20;
	localparam logic [6:0] HALF_D128 = 7'h40;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_SHIFT = 1'b1
	} spimsp_state_t;

	// half period of sck in system clocks
	function automatic logic [6:0] spimsp_half(input logic dbl,
		input logic [1:0] rate);
		logic [6:0] h;
		case (rate)
			2'b00: h = dbl ? HALF_D2 : HALF_D4;
			2'b01: h = dbl ? HALF_D8 : HALF_D16;
			2'b10: h = dbl ? HALF_D32 : HALF_D64;
			default: h = dbl ? HALF_D64 : HALF_D128;
		endcase
		return h;
	endfunction : spimsp_half
endpackage : spimsp_pkg

// ---- verilog/spimsp_clk_if.sv ----
// link between the transfer engine and the sck rate generator
interface spimsp_clk_if;
	logic run;
	logic [6:0] half;
	logic tick;
	modport gen (input run, input half, output tick);
	modport user (output run, output half, input tick);
endinterface : spimsp_clk_if

// ---- verilog/spimsp_sckgen.sv ----
// master sck rate generator: one tick per half period of sck
module spimsp_sckgen (
	input wire logic hclk, // system clock
	input wire logic hresetn, // async reset, active low
	spimsp_clk_if.gen clk_if // run, half period, tick
);
	typedef struct packed {
		logic [6:0] cnt;
		logic tick;
	} spimsp_gen_t;

	spimsp_gen_t s_ff;
	spimsp_gen_t nxt_s;

	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.tick = 1'b0;
		if (!clk_if.run)
		begin
			nxt_s.cnt = 7'h00;
		end
		else if (s_ff.cnt + 7'h01 >= clk_if.half)
		begin
			// equal high and low time at every division
			nxt_s.cnt = 7'h00;
			nxt_s.tick = 1'b1;
		end
		else
		begin
			nxt_s.cnt = s_ff.cnt + 7'h01;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	assign clk_if.tick = s_ff.tick;
endmodule : spimsp_sckgen

// ---- verilog/spimsp_top.sv ----
// spi master/slave port with an ahb-lite register slave
// Function
// - slave: select is input; select high ignores incoming data, pins input
// - slave: select high at once resets shifter, bit counter, partial byte
// - slave: select low activates port; miso drives only if set output
// - master: select as output is plain output, no effect on logic
// - master: select input low clears master_select, mosi and sck go input
// - lost master also sets transfer_done_flag, may raise interrupt
// - data launched on one sck edge, sampled on the other; modes 0-3
// - clock_idle_polarity 1 idles sck high, 0 idles low
// - clock_sample_phase 0 samples leading edge, 1 samples trailing edge
// - lsb_first_select at bit 5 sends lsb first when 1
// - block_enable at bit 6 required for every spi operation
// - master_select at bit 4: 1 master, 0 slave
// - transfer_irq_enable at bit 7 gates done flag onto interrupt
// - master sck is clock /4,/16,/64,/128, or /2,/8,/32,/64 doubled
// - rate bits have no effect in slave role
// - transfer_done_flag set when a byte transfer completes
// - flag cleared by vector taken, or status read then data access
// - data write during transfer sets write_collision_flag; cleared by status read then data access
// - status bits 5 to 1 read zero
// - data write starts transmission; data read returns receive buffer
// - double_rate in master gives a least sck period of two clocks
// - master data write runs clock for exactly eight bits then stops
// - transmit single buffered, receive double buffered, overrun loses byte
module spimsp_top (
	input wire logic hclk, // system clock
	input wire logic hresetn, // async reset, active low
	input wire logic hsel, // slave select of the bus
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic [2:0] hsize, // word transfers only
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic [31:0] hrdata, // read data
	output logic hreadyout, // always ready
	output logic hresp, // always okay
	input wire logic global_irq_enable, // cpu interrupt enable
	input wire logic irq_vector_taken, // pulse: vector taken
	output logic irq_req, // interrupt request
	input wire logic ss_n_i, // slave select pin level
	input wire logic ss_dir_out, // select pin set as output
	input wire logic sck_dir_out, // sck pin set as output
	input wire logic mosi_dir_out, // mosi pin set as output
	input wire logic miso_dir_out, // miso pin set as output
	input wire logic sck_i, // sck pin level
	output logic sck_o, // sck drive value
	output logic sck_oe, // sck drive enable
	input wire logic mosi_i, // mosi pin level
	output logic mosi_o, // mosi drive value
	output logic mosi_oe, // mosi drive enable
	input wire logic miso_i, // miso pin level
	output logic miso_o, // miso drive value
	output logic miso_oe // miso drive enable
);
	typedef struct packed {
		logic [7:0] ctrl;
		logic dbl;
		logic flag;
		logic write_collision_flag;
		logic armed;
		logic [7:0] txd;
		logic [7:0] rxsh;
		logic [7:0] rxbuf;
		spimsp_pkg::spimsp_state_t st;
		logic [4:0] edge_n;
		logic [3:0] nsamp;
		logic outbit;
		logic sck;
		logic sck_prev;
		logic wr_pend;
		logic [7:0] wr_idx;
		logic [31:0] rdata;
		logic irq;
		logic sck_oe;
		logic mosi_oe;
		logic miso_oe;
	} spimsp_core_t;

	spimsp_core_t s_ff;
	spimsp_core_t nxt_s;
	spimsp_clk_if clk_if ();

	spimsp_sckgen u_sckgen (
		.hclk (hclk),
		.hresetn (hresetn),
		.clk_if (clk_if)
	);

	function automatic logic bit_at(input logic [7:0] d,
		input logic [2:0] i, input logic lsb);
		return lsb ? d[i] : d[3'h7 - i];
	endfunction : bit_at

	logic en, master, clock_idle_polarity, clock_sample_phase, lsb;
	logic addr_ok, status_rd, data_rd, data_wr;
	logic active, lead, trail, sample, setup, in_bit, busy, done, mf;
	logic [7:0] aidx;
	logic [7:0] rx_next;

	assign en = s_ff.ctrl[spimsp_pkg::CTRL_EN_BIT];
	assign master = s_ff.ctrl[spimsp_pkg::CTRL_MASTER_SELECT_BIT];
	assign clock_idle_polarity = s_ff.ctrl[spimsp_pkg::CTRL_CLOCK_IDLE_POLARITY_BIT];
	assign clock_sample_phase = s_ff.ctrl[spimsp_pkg::CTRL_CLOCK_SAMPLE_PHASE_BIT];
	assign lsb = s_ff.ctrl[spimsp_pkg::CTRL_LSB_BIT];
	assign aidx = haddr[spimsp_pkg::ADDR_MSB:spimsp_pkg::ADDR_LSB];
	assign addr_ok = hsel && hready && htrans[1];
	assign clk_if.run = (s_ff.st == spimsp_pkg::ST_SHIFT) && master;
	// rate bits only reach the generator, which runs in master role
	assign clk_if.half = spimsp_pkg::spimsp_half(s_ff.dbl,
		s_ff.ctrl[spimsp_pkg::CTRL_R1_BIT:spimsp_pkg::CTRL_R0_BIT]);

	// ********************************************************
	// next state
	// ********************************************************
	always_comb
	begin
		nxt_s = s_ff;
		status_rd = 1'b0;
		data_rd = 1'b0;
		data_wr = 1'b0;
		nxt_s.rdata = 32'h0000_0000;
		// bus: reads answer in the data phase straight from a flop
		if (addr_ok && !hwrite)
		begin
			case (aidx)
				spimsp_pkg::CTRL_IDX: nxt_s.rdata = {24'h00_0000, s_ff.ctrl};
				spimsp_pkg::STAT_IDX:
				begin
					nxt_s.rdata = {24'h00_0000, s_ff.flag, s_ff.write_collision_flag,
						5'h00, s_ff.dbl};
					status_rd = 1'b1;
				end
				spimsp_pkg::DATA_IDX:
				begin
					nxt_s.rdata = {24'h00_0000, s_ff.rxbuf};
					data_rd = 1'b1;
				end
				default: nxt_s.rdata = 32'h0000_0000;
			endcase
		end
		nxt_s.wr_pend = addr_ok && hwrite;
		nxt_s.wr_idx = aidx;
		if (s_ff.wr_pend)
		begin
			case (s_ff.wr_idx)
				spimsp_pkg::CTRL_IDX: nxt_s.ctrl = hwdata[7:0];
				spimsp_pkg::STAT_IDX:
					nxt_s.dbl = hwdata[spimsp_pkg::STAT_DBL_BIT];
				spimsp_pkg::DATA_IDX: data_wr = 1'b1;
				default: ;
			endcase
		end
		// flag clearing sequence; a same-cycle set below still wins
		if (s_ff.armed && (data_rd || data_wr))
		begin
			nxt_s.flag = 1'b0;
			nxt_s.write_collision_flag = 1'b0;
			nxt_s.armed = 1'b0;
		end
		if (status_rd && (s_ff.flag || s_ff.write_collision_flag))
			nxt_s.armed = 1'b1;
		if (irq_vector_taken)
			nxt_s.flag = 1'b0;

		// engine: edges from the generator (master) or the pin (slave)
		active = en && !master && !ss_n_i;
		in_bit = master ? miso_i : mosi_i;
		if (master)
		begin
			lead = clk_if.run && clk_if.tick && !s_ff.edge_n[0];
			trail = clk_if.run && clk_if.tick && s_ff.edge_n[0];
		end
		else
		begin
			lead = active && (s_ff.sck_prev == clock_idle_polarity) && (sck_i != clock_idle_polarity);
			trail = active && (s_ff.sck_prev != clock_idle_polarity) && (sck_i == clock_idle_polarity);
		end
		sample = clock_sample_phase ? trail : lead;
		setup = clock_sample_phase ? lead : trail;
		nxt_s.sck_prev = sck_i;
		busy = master ? (s_ff.st == spimsp_pkg::ST_SHIFT)
			: (active && s_ff.nsamp != 4'h0);
		rx_next = s_ff.rxsh;
		if (sample)
		begin
			rx_next = lsb ? {in_bit, s_ff.rxsh[7:1]}
				: {s_ff.rxsh[6:0], in_bit};
			nxt_s.rxsh = rx_next;
			nxt_s.nsamp = s_ff.nsamp + 4'h1;
		end
		if (setup)
			nxt_s.outbit = bit_at(s_ff.txd, nxt_s.nsamp[2:0], lsb);
		if (master)
		begin
			done = clk_if.tick && s_ff.edge_n == spimsp_pkg::LAST_EDGE;
			if (clk_if.tick)
			begin
				nxt_s.sck = !s_ff.sck;
				nxt_s.edge_n = s_ff.edge_n + 5'h01;
			end
			if (done)
				nxt_s.st = spimsp_pkg::ST_IDLE;
		end
		else
		begin
			done = sample && s_ff.nsamp == spimsp_pkg::LAST_SAMPLE;
			nxt_s.st = spimsp_pkg::ST_IDLE;
			if (done)
				nxt_s.nsamp = 4'h0;
			if (!active)
			begin
				// select high drops the partial byte at once
				nxt_s.nsamp = 4'h0;
				nxt_s.rxsh = 8'h00;
				nxt_s.outbit = bit_at(s_ff.txd, 3'h0, lsb);
				done = 1'b0;
			end
		end
		if (done)
		begin
			// overwritten if software was late: the older byte is lost
			nxt_s.rxbuf = rx_next;
			nxt_s.flag = 1'b1;
		end
		if (data_wr)
		begin
			if (busy)
				nxt_s.write_collision_flag = 1'b1;
			else
			begin
				nxt_s.txd = hwdata[7:0];
				nxt_s.outbit = bit_at(hwdata[7:0], 3'h0, lsb);
				if (master && en)
				begin
					nxt_s.st = spimsp_pkg::ST_SHIFT;
					nxt_s.edge_n = 5'h00;
					nxt_s.nsamp = 4'h0;
				end
			end
		end
		// select as an input pulled low: another master took the bus
		mf = en && master && !ss_dir_out && !ss_n_i;
		if (mf)
		begin
			nxt_s.ctrl[spimsp_pkg::CTRL_MASTER_SELECT_BIT] = 1'b0;
			nxt_s.flag = 1'b1;
			nxt_s.st = spimsp_pkg::ST_IDLE;
			nxt_s.edge_n = 5'h00;
			nxt_s.nsamp = 4'h0;
		end
		if (!en)
		begin
			nxt_s.st = spimsp_pkg::ST_IDLE;
			nxt_s.nsamp = 4'h0;
		end
		// idle level moves with a control write, not one edge later
		if (nxt_s.st == spimsp_pkg::ST_IDLE)
			nxt_s.sck = nxt_s.ctrl[spimsp_pkg::CTRL_CLOCK_IDLE_POLARITY_BIT];
		nxt_s.sck_oe = nxt_s.ctrl[spimsp_pkg::CTRL_EN_BIT]
			&& nxt_s.ctrl[spimsp_pkg::CTRL_MASTER_SELECT_BIT] && sck_dir_out;
		nxt_s.mosi_oe = nxt_s.ctrl[spimsp_pkg::CTRL_EN_BIT]
			&& nxt_s.ctrl[spimsp_pkg::CTRL_MASTER_SELECT_BIT] && mosi_dir_out;
		nxt_s.miso_oe = nxt_s.ctrl[spimsp_pkg::CTRL_EN_BIT]
			&& !nxt_s.ctrl[spimsp_pkg::CTRL_MASTER_SELECT_BIT]
			&& !ss_n_i && miso_dir_out;
		nxt_s.irq = nxt_s.flag && global_irq_enable
			&& nxt_s.ctrl[spimsp_pkg::CTRL_IE_BIT];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s_ff <= '0;
			s_ff.ctrl <= spimsp_pkg::CTRL_RST;
			s_ff.txd <= spimsp_pkg::DATA_RST;
			s_ff.st <= spimsp_pkg::ST_IDLE;
		end
		else
			s_ff <= nxt_s;
	end

	assign hrdata = s_ff.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign irq_req = s_ff.irq;
	assign sck_o = s_ff.sck;
	assign sck_oe = s_ff.sck_oe;
	assign mosi_o = s_ff.outbit;
	assign mosi_oe = s_ff.mosi_oe;
	assign miso_o = s_ff.outbit;
	assign miso_oe = s_ff.miso_oe;

	// ********************************************************
	// assertions
	// ********************************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_ss_quiet;
		!master && ss_n_i |=> !miso_oe;
	endproperty
	a_ss_quiet: assert property (p_ss_quiet)
		else $error("miso driven while deselected");

	property p_ss_reset;
		!master && ss_n_i |=> s_ff.nsamp == 4'h0 && s_ff.rxsh == 8'h00;
	endproperty
	a_ss_reset: assert property (p_ss_reset)
		else $error("slave shifter not reset by select");

	property p_lost_master;
		en && master && !ss_dir_out && !ss_n_i
			|=> !master && s_ff.flag && s_ff.st == spimsp_pkg::ST_IDLE;
	endproperty
	a_lost_master: assert property (p_lost_master)
		else $error("lost master not handled");

	property p_irq;
		irq_req == (s_ff.flag && s_ff.ctrl[spimsp_pkg::CTRL_IE_BIT]
			&& $past(global_irq_enable));
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt request mismatch");

	property p_reserved;
		$past(status_rd) |-> hrdata[5:1] == 5'h00;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved status bits not zero");

	property p_sck_idle;
		master && s_ff.st == spimsp_pkg::ST_IDLE && $stable(clock_idle_polarity)
			|=> sck_o == clock_idle_polarity;
	endproperty
	a_sck_idle: assert property (p_sck_idle)
		else $error("sck not at idle level");

	property p_half_period;
		clk_if.run && !s_ff.dbl && $changed(sck_o) |=> $stable(sck_o);
	endproperty
	a_half_period: assert property (p_half_period)
		else $error("sck half period too short");

	property p_byte_time;
		data_wr && master && en && !busy && !s_ff.dbl && !mf
			&& s_ff.ctrl[1:0] == 2'b00
			|=> s_ff.st == spimsp_pkg::ST_SHIFT ##[30:34] s_ff.flag;
	endproperty
	a_byte_time: assert property (p_byte_time)
		else $error("master byte did not finish on time");

	property p_collision;
		data_wr && busy |=> s_ff.write_collision_flag && $stable(s_ff.txd);
	endproperty
	a_collision: assert property (p_collision)
		else $error("collision not flagged");

	c_master_done: cover property (master && done);
	c_slave_done: cover property (!master && done);
	c_lost_master: cover property (mf);
	c_collision: cover property (data_wr && busy);
endmodule : spimsp_top

// ---- verification/spimsp_peer_model.sv ----
// behavioural spi slave facing the port while it is master
module spimsp_peer_model (
	input wire logic sck, // serial clock level
	input wire logic mosi, // data from the port
	input wire logic ss_n, // select, active low
	input wire logic clock_idle_polarity, // sck idle level
	input wire logic clock_sample_phase, // sample on trailing edge
	input wire logic lsb, // lsb first
	input wire logic [7:0] tx, // byte returned
	output logic miso, // data to the port
	output logic [7:0] rx // byte received
);
	timeunit 1ns;
	timeprecision 1ns;
	int ptr;
	initial
	begin
		miso = 1'b0;
		rx = 8'h00;
		ptr = 0;
	end
	function automatic logic pick(input int k);
		return lsb ? tx[k] : tx[7 - k];
	endfunction : pick
	always @(negedge ss_n)
	begin
		ptr = 0;
		if (!clock_sample_phase)
			miso = pick(0);
	end
	// released line must not keep showing the last bit
	always @(posedge ss_n)
		miso = ~miso;
	always @(sck)
	begin
		if (!ss_n && (sck ^ clock_idle_polarity ^ clock_sample_phase))
			rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
		else if (!ss_n)
		begin
			if (!clock_sample_phase)
				ptr++;
			if (ptr < 8)
				miso = pick(ptr);
			if (clock_sample_phase)
				ptr++;
		end
	end
endmodule : spimsp_peer_model

// ---- verification/spi_master_slave_port_bench.sv ----
// self-checking bench of the spi master/slave port
module spi_master_slave_port_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic hreadyout, hresp, gie = 1'b0, vec = 1'b0, irq;
	logic ss_pin = 1'b1, ss_dir = 1'b1, sck_dir = 1'b1;
	logic mosi_dir = 1'b1, miso_dir = 1'b0, bsck = 1'b0, bmosi = 1'b0;
	logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, sck_q;
	logic pmiso, sck_w, mosi_w, miso_w;
	logic [7:0] ctrl, ptx, mtx, prx, st, got, peer_tx = 8'h00;
	logic [7:0] exp_q[$];
	logic [31:0] rd;
	int n_mismatch = 0, n_checks = 0, cyc = 0, n_edge = 0;
	int t_first = 0, t_last = 0, k;
	int hv[4] = '{2, 8, 32, 64};
	assign sck_w = sck_oe ? sck_o : bsck;
	assign mosi_w = mosi_oe ? mosi_o : bmosi;
	assign miso_w = miso_oe ? miso_o : pmiso;
	always #50 hclk = ~hclk;
	spimsp_top spimsp_top_inst (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.global_irq_enable(gie), .irq_vector_taken(vec),
		.irq_req(irq), .ss_n_i(ss_pin), .ss_dir_out(ss_dir),
		.sck_dir_out(sck_dir), .mosi_dir_out(mosi_dir),
		.miso_dir_out(miso_dir), .sck_i(sck_w), .sck_o(sck_o),
		.sck_oe(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o),
		.mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
		.miso_oe(miso_oe));
	spimsp_peer_model spimsp_peer_model_inst (.sck(sck_w), .mosi(mosi_w),
		.ss_n(ss_pin), .clock_idle_polarity(ctrl[3]), .clock_sample_phase(ctrl[2]), .lsb(ctrl[5]),
		.tx(peer_tx), .miso(pmiso), .rx(prx));
	// ****************************************
	// sck edge monitor and hang guard
	// ****************************************
	always @(posedge hclk)
	begin
		cyc++;
		sck_q <= sck_o;
		if (hresetn && sck_o !== sck_q)
		begin
			if (n_edge == 0)
				t_first = cyc;
			t_last = cyc;
			n_edge++;
		end
		if (cyc > 60000)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	task automatic chk8(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		n_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk8
	task automatic chk1(input string nm, input logic e, input logic g);
		chk8(nm, {7'h00, e}, {7'h00, g});
	endtask : chk1
	task automatic bus(input logic w, input logic [7:0] idx,
		input logic [7:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= {24'h0, wd};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk1("hresp", 1'b0, hresp);
		chk1("hreadyout", 1'b1, hreadyout);
	endtask : bus
	task automatic poll_done();
		k = 0;
		do
		begin
			bus(1'b0, spimsp_pkg::STAT_IDX, 8'h00);
			k++;
		end
		while (rd[7] !== 1'b1 && k < 400);
		st = rd[7:0];
	endtask : poll_done
	// bench acts as remote master, mode 0, half period of four clocks
	task automatic spi_send(input logic [7:0] tx, input int nb);
		for (int b = 0; b < nb; b++)
		begin
			bmosi <= tx[7 - b];
			repeat (4) @(posedge hclk);
			got = {got[6:0], miso_w};
			bsck <= 1'b1;
			repeat (4) @(posedge hclk);
			bsck <= 1'b0;
		end
	endtask : spi_send
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		void'($urandom(8));
		ctrl = 8'h00;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, spimsp_pkg::CTRL_IDX, 8'h00);
		chk8("control reset", spimsp_pkg::CTRL_RST, rd[7:0]);
		bus(1'b0, spimsp_pkg::STAT_IDX, 8'h00);
		chk8("status reset", spimsp_pkg::STAT_RST, rd[7:0]);
		bus(1'b1, 8'h2F, 8'hA5);
		bus(1'b0, 8'h2F, 8'h00);
		chk8("unmapped", 8'h00, rd[7:0]);
		$display("test reset done");
		for (int i = 0; i < 8; i++)
		begin
			ctrl = {2'b11, i[2], 1'b1, i[1:0], i[2:1]};
			gie <= i[0];
			bus(1'b1, spimsp_pkg::CTRL_IDX, ctrl);
			bus(1'b1, spimsp_pkg::STAT_IDX, {7'h00, i[0]});
			ptx = 8'($urandom);
			mtx = 8'($urandom);
			peer_tx = ptx;
			exp_q.push_back(ptx);
			ss_pin <= 1'b0;
			repeat (2) @(posedge hclk);
			n_edge = 0;
			bus(1'b1, spimsp_pkg::DATA_IDX, mtx);
			if (i == 3)
				bus(1'b1, spimsp_pkg::DATA_IDX, ~mtx);
			poll_done();
			chk8("status done", {1'b1, i == 3, 5'h00, i[0]}, st);
			chk1("irq", i[0], irq);
			chk8("sck edges", 8'h10, 8'(n_edge));
			chk8("sck span", 8'(15 * (hv[i[2:1]] >> i[0])),
				8'(t_last - t_first));
			chk1("sck idle", ctrl[3], sck_o);
			chk8("peer rx", mtx, prx);
			if (i == 5)
			begin
				@(posedge hclk);
				vec <= 1'b1;
				@(posedge hclk);
				vec <= 1'b0;
				repeat (2) @(posedge hclk);
				chk1("irq cleared", 1'b0, irq);
			end
			bus(1'b0, spimsp_pkg::DATA_IDX, 8'h00);
			chk8("rx data", exp_q.pop_front(), rd[7:0]);
			bus(1'b0, spimsp_pkg::STAT_IDX, 8'h00);
			chk8("status clear", {7'h00, i[0]}, rd[7:0]);
			ss_pin <= 1'b1;
			$display("test master %0d done", i);
		end
		gie <= 1'b1;
		bus(1'b1, spimsp_pkg::STAT_IDX, 8'h00);
		bus(1'b1, spimsp_pkg::CTRL_IDX, 8'hD0);
		ss_dir <= 1'b0;
		repeat (3) @(posedge hclk);
		chk1("held master", 1'b1, sck_oe);
		ss_pin <= 1'b0;
		repeat (4) @(posedge hclk);
		chk1("lost irq", 1'b1, irq);
		chk1("lost sck oe", 1'b0, sck_oe);
		chk1("lost mosi oe", 1'b0, mosi_oe);
		bus(1'b0, spimsp_pkg::CTRL_IDX, 8'h00);
		chk8("lost control", 8'hC0, rd[7:0]);
		bus(1'b0, spimsp_pkg::STAT_IDX, 8'h00);
		chk8("lost status", 8'h80, rd[7:0]);
		bus(1'b0, spimsp_pkg::DATA_IDX, 8'h00);
		ss_pin <= 1'b1;
		$display("test lost master done");
		bus(1'b1, spimsp_pkg::CTRL_IDX, 8'h43);
		miso_dir <= 1'b1;
		repeat (2) @(posedge hclk);
		chk1("miso idle", 1'b0, miso_oe);
		ss_pin <= 1'b0;
		spi_send(8'hFF, 3);
		ss_pin <= 1'b1;
		ptx = 8'($urandom);
		mtx = 8'($urandom);
		bus(1'b1, spimsp_pkg::DATA_IDX, ptx);
		ss_pin <= 1'b0;
		repeat (2) @(posedge hclk);
		chk1("miso drive", 1'b1, miso_oe);
		spi_send(mtx, 8);
		ss_pin <= 1'b1;
		chk8("slave miso", ptx, got);
		poll_done();
		chk8("slave status", 8'h80, st);
		bus(1'b0, spimsp_pkg::DATA_IDX, 8'h00);
		chk8("slave rx", mtx, rd[7:0]);
		$display("test slave done");
		tally_and_finish();
	end
endmodule : spi_master_slave_port_bench
